// ===== rtl/buck1_command_register.v
`include "buck1_cmd_map.vh"

module buck1_command_register #(
    // Register width
    parameter DATA_W = 8,
    // Register address width
    parameter ADDR_W = 8,
    // Slew code width
    parameter SLEW_W = 3,
    // Pace counter width; must hold 2^(2^SLEW_W - 1) - 1
    parameter PACE_W = 7
) (
    // Clock and reset
    input  wire              sys_clk,
    input  wire              rst_n,

    // Register access from the serial slave
    input  wire              wr_commit,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [DATA_W-1:0] wr_data,
    input  wire [ADDR_W-1:0] rd_addr,
    output reg  [DATA_W-1:0] rd_data_r,

    // Switching cycle pulse and the external mode level
    input  wire              switch_tick,
    input  wire              mode_pin,

    // Regulator controls
    output reg               step_tick_r,
    output reg               forced_pwm_r,
    output reg               pulse_skipping_r,
    output reg               output_one_off_r
);

    // Counter- and data-width constants, so no shift or sum below widens silently
    localparam [PACE_W-1:0] PACE_ONE  = {{(PACE_W-1){1'b0}}, 1'b1};
    localparam [PACE_W-1:0] PACE_ZERO = {PACE_W{1'b0}};
    localparam [DATA_W-1:0] DATA_ZERO = {DATA_W{1'b0}};

    // Command register state and its next value
    reg  [DATA_W-1:0] cmd_r;
    reg  [DATA_W-1:0] cmd_nxt;

    // Readback next value
    reg  [DATA_W-1:0] rd_data_nxt;

    // Pace divider state
    reg  [PACE_W-1:0] pace_cnt_r;
    reg  [PACE_W-1:0] pace_cnt_nxt;
    reg               pace_hit;

    // Control next values
    reg               forced_pwm_nxt;
    reg               pulse_skipping_nxt;
    reg               output_one_off_nxt;

    // Address decode and masked write data
    wire              write_hit;
    wire              read_hit;
    wire [DATA_W-1:0] write_value;

    // Fields of the stored command
    wire [SLEW_W-1:0] slew_code;
    wire [1:0]        light_load_select;
    wire              off_request;
    wire [PACE_W-1:0] pace_limit;

    // Write decode; the commit strobe only ever rises once the byte is complete
    assign write_hit   = wr_commit && (wr_addr == `CH1_CMD_OFFSET);
    // Reserved bits are dropped on the way in, so a careless host cannot set them
    assign write_value = wr_data & `CH1_CMD_WMASK;
    // Read decode
    assign read_hit    = (rd_addr == `CH1_CMD_OFFSET);

    // Field extraction
    assign slew_code         = cmd_r[`CH1_SLEW_MSB:`CH1_SLEW_LSB];
    assign light_load_select = cmd_r[`CH1_LL_MSB:`CH1_LL_LSB];
    assign off_request       = cmd_r[`CH1_OFF_BIT];

    // Terminal count 2^code - 1; at the top code the shift wraps to zero
    // and the subtraction wraps back to the all-ones count, as intended
    assign pace_limit = (PACE_ONE << slew_code) - PACE_ONE;

    // Register next value: hold unless the slave commits a write here
    always @* begin
        cmd_nxt = cmd_r;
        if (write_hit) begin
            cmd_nxt = write_value;
        end
    end

    // Command register; never loaded mid-byte, so a partial value is never seen
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= `CH1_CMD_RESET;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    // Readback next value; other offsets read as zero
    always @* begin
        rd_data_nxt = DATA_ZERO;
        if (read_hit) begin
            rd_data_nxt = cmd_r;
        end
    end

    // Registered readback costs one cycle but keeps the output glitch free
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= DATA_ZERO;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // Pace divider over switching cycles. The count is not cleared on a write:
    // a limit lowered to or below the count makes the next tick a hit at once, which keeps the step
    // cadence from stalling for a long span after a slew change.
    always @* begin
        pace_hit     = 1'b0;
        pace_cnt_nxt = pace_cnt_r;
        if (switch_tick) begin
            if (pace_cnt_r >= pace_limit) begin
                pace_hit     = 1'b1;
                pace_cnt_nxt = PACE_ZERO;
            end else begin
                pace_cnt_nxt = pace_cnt_r + PACE_ONE;
            end
        end
    end

    // Pace counter
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pace_cnt_r <= PACE_ZERO;
        end else begin
            pace_cnt_r <= pace_cnt_nxt;
        end
    end

    // Step permission, one cycle wide, one clock after the terminal tick
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_tick_r <= 1'b0;
        end else begin
            step_tick_r <= pace_hit;
        end
    end

    // Mode decode; the reserved code falls back to forced PWM, the safe choice
    always @* begin
        forced_pwm_nxt     = 1'b0;
        pulse_skipping_nxt = 1'b0;
        output_one_off_nxt = off_request;
        case (light_load_select)
            `LL_FROM_PIN: begin
                forced_pwm_nxt     = mode_pin;
                pulse_skipping_nxt = ~mode_pin;
            end
            `LL_FORCED_PWM: begin
                forced_pwm_nxt     = 1'b1;
                pulse_skipping_nxt = 1'b0;
            end
            `LL_PULSE_SKIP: begin
                forced_pwm_nxt     = 1'b0;
                pulse_skipping_nxt = 1'b1;
            end
            default: begin
                forced_pwm_nxt     = 1'b1;
                pulse_skipping_nxt = 1'b0;
            end
        endcase
    end

    // Forced PWM control
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            forced_pwm_r <= 1'b0;
        end else begin
            forced_pwm_r <= forced_pwm_nxt;
        end
    end

    // Pulse skipping control
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_skipping_r <= 1'b0;
        end else begin
            pulse_skipping_r <= pulse_skipping_nxt;
        end
    end

    // Output disable; enabled out of reset
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_one_off_r <= 1'b0;
        end else begin
            output_one_off_r <= output_one_off_nxt;
        end
    end

endmodule

// ===== common/buck1_cmd_map.vh
`ifndef BUCK1_CMD_MAP_VH
`define BUCK1_CMD_MAP_VH

// Register offset within the regulator's register space
`define CH1_CMD_OFFSET      8'h02
// Field positions
`define CH1_SLEW_MSB        6
`define CH1_SLEW_LSB        4
`define CH1_LL_MSB          2
`define CH1_LL_LSB          1
`define CH1_OFF_BIT         0
// Writable bits; reserved bits 7 and 3 are masked
`define CH1_CMD_WMASK       8'h77
`define CH1_CMD_RESET       8'h00
// Light-load codes
`define LL_FROM_PIN         2'h0
`define LL_FORCED_PWM       2'h1
`define LL_PULSE_SKIP       2'h2
`define LL_RESERVED         2'h3

`endif

// ===== verif/buck1_cmd_assertions.sv
module buck1_cmd_assertions(input wire sys_clk,rst_n,wr_commit,input wire [7:0] wr_addr,wr_data,rd_addr,rd_data_r,
    input wire switch_tick,mode_pin,step_tick_r,forced_pwm_r,pulse_skipping_r,output_one_off_r);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // A hit on the command register shows at the controls two edges later
    property p_off; wr_commit&&wr_addr==8'h02 |-> ##2 output_one_off_r==$past(wr_data[0],2); endproperty
    a_off: assert property(p_off) else $error("off bit wrong");
    property p_pwm; wr_commit&&wr_addr==8'h02&&wr_data[2:1]==2'h1 |-> ##2 forced_pwm_r&&!pulse_skipping_r; endproperty
    a_pwm: assert property(p_pwm) else $error("forced mode wrong");
    property p_skip; wr_commit&&wr_addr==8'h02&&wr_data[2:1]==2'h2 |-> ##2 pulse_skipping_r&&!forced_pwm_r; endproperty
    a_skip: assert property(p_skip) else $error("skip mode wrong");
    property p_rsv; rd_data_r[7]==1'b0&&rd_data_r[3]==1'b0; endproperty
    a_rsv: assert property(p_rsv) else $error("reserved bit set");
    property p_step; step_tick_r |-> $past(switch_tick); endproperty
    a_step: assert property(p_step) else $error("step without tick");
    // Without a commit the off level must not move
    property p_hold; !wr_commit ##1 !wr_commit |=> $stable(output_one_off_r); endproperty
    a_hold: assert property(p_hold) else $error("off bit moved");
endmodule
bind buck1_command_register buck1_cmd_assertions u_chk(.sys_clk,.rst_n,.wr_commit,.wr_addr,.wr_data,.rd_addr,
    .rd_data_r,.switch_tick,.mode_pin,.step_tick_r,.forced_pwm_r,.pulse_skipping_r,.output_one_off_r);

// ===== verif/host_writer.sv
// Host side: released lines invert on every clock, so the old value returns every second clock
module host_writer(input wire sys_clk,go,input wire [7:0] a,d,output logic wr_commit,output logic [7:0] wr_addr,wr_data);
    timeunit 1ns; timeprecision 1ns;
    always @(posedge sys_clk) begin
        wr_commit <= go;
        wr_addr   <= go ? a : ~wr_addr;
        wr_data   <= go ? d : ~wr_data;
    end
endmodule

// ===== verif/buck1_command_register_tb.sv
module buck1_command_register_tb;
    timeunit 1ns; timeprecision 1ns;
    logic sys_clk=0,rst_n=0,go=0,switch_tick=0,mode_pin=0,wr_commit,step_tick_r,forced_pwm_r,pulse_skipping_r;
    logic output_one_off_r;
    logic [7:0] a=0,d=0,rd_addr=8'h02,wr_addr,wr_data,rd_data_r,r=8'h63;
    int error_cnt=0,num_checks=0,cmd=0,ll,n;
    host_writer u_host(.sys_clk,.go,.a,.d,.wr_commit,.wr_addr,.wr_data);
    buck1_command_register u_dut(.sys_clk,.rst_n,.wr_commit,.wr_addr,.wr_data,.rd_addr,.rd_data_r,.switch_tick,
        .mode_pin,.step_tick_r,.forced_pwm_r,.pulse_skipping_r,.output_one_off_r);
    function logic [7:0] lfsr(logic [7:0] v); return {v[6:0],v[7]^v[5]^v[4]^v[3]}; endfunction
    task chk(logic [7:0] g,e);
        num_checks++;
        if (g!==e) begin error_cnt++; $display("MISMATCH %0t got %h exp %h",$time,g,e); end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d",num_checks,error_cnt);
        if (error_cnt==0&&num_checks>0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #5 sys_clk=~sys_clk;
    always @(posedge sys_clk) switch_tick <= ~switch_tick;
    // Run needs about 1400 cycles, so 6000 is ample
    initial begin #60000; error_cnt++; report_and_stop; end
    initial begin
        repeat(2) @(posedge sys_clk);
        rst_n <= 1;
        for (int i=0;i<40;i++) begin
            @(posedge sys_clk); r=lfsr(r); go<=1; a<=r[0]?8'h02:(r|8'h01); d<=r^8'h5a; mode_pin<=r[1];
            if (r[0]) cmd=(r^8'h5a)&8'h77;
            @(posedge sys_clk); go<=0; repeat(4) @(posedge sys_clk); #1;
            ll=(cmd>>1)&3;
            chk(rd_data_r,cmd);
            chk(output_one_off_r,cmd&1);
            chk(forced_pwm_r,ll==1||ll==3||(ll==0&&mode_pin));
            chk(pulse_skipping_r,ll==2||(ll==0&&!mode_pin));
        end
        // Other offsets read zero
        @(posedge sys_clk); rd_addr<=8'h03;
        repeat(2) @(posedge sys_clk); #1;
        chk(rd_data_r,8'h00);
        // Mid-run reset clears the register and the controls
        @(posedge sys_clk); rd_addr<=8'h02; rst_n<=0;
        repeat(2) @(posedge sys_clk); #1;
        chk(rd_data_r,8'h00);
        chk(output_one_off_r,0);
        chk(forced_pwm_r|pulse_skipping_r,0);
        @(posedge sys_clk); rst_n<=1; cmd=0;
        repeat(2) @(posedge sys_clk); #1;
        chk(forced_pwm_r,mode_pin);
        chk(pulse_skipping_r,!mode_pin);
        // Slew pace: a switching tick every second clock, a step every 2^code ticks
        for (int k=0;k<8;k++) begin
            @(posedge sys_clk); go<=1; a<=8'h02; d<=8'(k<<4);
            @(posedge sys_clk); go<=0; repeat(8) @(posedge sys_clk);
            n=0; do begin @(posedge sys_clk); #1; n++; end while (!step_tick_r&&n<600);
            n=0; do begin @(posedge sys_clk); #1; n++; end while (!step_tick_r&&n<600);
            chk(n>>1,1<<k);
        end
        report_and_stop;
    end
endmodule
